// ---- pkg/vpi_regs.svh ----
`ifndef VPI_REGS_SVH
`define VPI_REGS_SVH

// Register numbers with a fixed meaning in the register file.
`define VPI_ZERO_REG  6'h00
`define VPI_LINK_REG  6'h3F

// Operation latency classes.
`define VPI_LAT_ONE   2'h1
`define VPI_LAT_TWO   2'h2
`define VPI_LAT_THREE 2'h3

// Cycles between a link register write and a shadow dependent operation.
`define VPI_LINK_LAT  3'h4

`endif

// ---- pkg/vpi_pkg.sv ----
package vpi_pkg;

   // Control class of a bundle as seen by decode.
   typedef enum logic [2:0] {
      VPI_OP_PLAIN   = 3'h0,
      VPI_OP_BRANCH  = 3'h1,
      VPI_OP_LINKBR  = 3'h2,
      VPI_OP_RFI     = 3'h3,
      VPI_OP_PSWMASK = 3'h4,
      VPI_OP_SYNCINS = 3'h5
   } vpi_kind_t;

   // Operand source chosen at the start of the first execute stage.
   typedef enum logic [1:0] {
      VPI_BYP_RF  = 2'h0,
      VPI_BYP_EX2 = 2'h1,
      VPI_BYP_WB  = 2'h2,
      VPI_BYP_RET = 2'h3
   } vpi_byp_t;

   // Fetch gate after a taken branch.
   typedef enum logic [1:0] {
      VPI_FG_OPEN = 2'b01,
      VPI_FG_LINE = 2'b10
   } vpi_fgate_t;

   // Contents of one pipeline stage.
   typedef struct packed {
      logic        v;
      logic [5:0]  dest;
      logic [5:0]  src_a;
      logic [5:0]  src_b;
      logic [1:0]  lat;
      logic        wload;
      vpi_kind_t   kind;
   } vpi_stage_t;

endpackage : vpi_pkg

// ---- hdl/vpi_src_check.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "vpi_regs.svh"

module vpi_src_check (
   input  wire logic            en,
   input  wire logic [5:0]      src,
   input  wire logic            ex1_v,
   input  wire logic [5:0]      ex1_dest,
   input  wire logic [1:0]      ex1_lat,
   input  wire logic            ex2_v,
   input  wire logic [5:0]      ex2_dest,
   input  wire logic [1:0]      ex2_lat,
   input  wire logic            wb_v,
   input  wire logic [5:0]      wb_dest,
   output logic                 stall,
   output vpi_pkg::vpi_byp_t    sel
);
   import vpi_pkg::*;

   logic hit1;
   logic hit2;
   logic hit3;

   always_comb begin
      hit1  = en && ex1_v && (ex1_dest == src) && (src != `VPI_ZERO_REG);
      hit2  = en && ex2_v && (ex2_dest == src) && (src != `VPI_ZERO_REG);
      hit3  = en && wb_v && (wb_dest == src) && (src != `VPI_ZERO_REG);
      stall = 1'b0;
      sel   = VPI_BYP_RF;
      // Nearest producer wins; a result not yet ready stalls the reader.
      if (hit1) begin
         stall = (ex1_lat != `VPI_LAT_ONE);
         sel   = VPI_BYP_EX2;
      end else if (hit2) begin
         stall = (ex2_lat == `VPI_LAT_THREE);
         sel   = VPI_BYP_WB;
      end else if (hit3) begin
         sel   = VPI_BYP_RET;
      end
   end

endmodule : vpi_src_check

`default_nettype wire

// ---- hdl/vpi_link_guard.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "vpi_regs.svh"

module vpi_link_guard (
   input  wire logic ref_clk,
   input  wire logic resetn,
   input  wire logic load,
   output logic      busy
);
   import vpi_pkg::*;

   logic [2:0] cnt_reg;
   logic [2:0] cnt_next;

   always_comb begin
      if (load) begin
         cnt_next = `VPI_LINK_LAT;
      end else if (cnt_reg != 3'h0) begin
         cnt_next = cnt_reg - 3'h1;
      end else begin
         cnt_next = 3'h0;
      end
      busy = (cnt_reg != 3'h0);
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cnt_reg <= 3'h0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

endmodule : vpi_link_guard

`default_nettype wire

// ---- hdl/vpi_pipe_ctrl.sv ----
// What this block does
// - Six stages: fetch, decode, read, execute one, execute two, writeback.
// - Fetch hands syllables assembled into bundles to decode.
// - Decode resolves and executes branches before register read.
// - Register files are read in the stage before execute one.
// - Operations start in execute one with operands from file or bypass.
// - Results and state are committed only at the end of writeback.
// - Loads, divides and remainders over three cycles freeze the whole pipeline.
// - Results produced before writeback are forwarded to later operations.
// - Logic ops take one cycle, arithmetic one to three.
// - Loads and stores take three cycles and stall for slow memory.
// - Every latency is enforced by stalls, except saved-register stores before return.
// - Untaken branches cost nothing; taken branches stall exactly one cycle.
// - A taken target crossing a cache line adds one more stall.
// - A taken branch discards unexecuted operations held in fetch.
// - Returns and link-register jumps use the speculative link shadow.
// - Four cycles of interlock between link register write and shadow use.
// - Only one-cycle ops and word loads may write the link register.
// - Return, status-mask update and instruction sync drain the whole pipeline.
`timescale 1ns/10ps
`default_nettype none
`include "vpi_regs.svh"

module vpi_pipe_ctrl (
   input  wire logic                ref_clk,
   input  wire logic                resetn,
   input  wire logic                fch_valid,
   input  wire logic [5:0]          fch_dest,
   input  wire logic [5:0]          fch_src_a,
   input  wire logic [5:0]          fch_src_b,
   input  wire logic [1:0]          fch_lat,
   input  wire logic                fch_word_load,
   input  wire vpi_pkg::vpi_kind_t  fch_kind,
   input  wire logic                br_taken,
   input  wire logic                br_line_cross,
   input  wire logic                long_busy,
   output logic                     fch_take,
   output logic                     fch_flush,
   output logic                     rd_valid,
   output logic                     ex1_valid,
   output logic                     ex2_valid,
   output logic                     wb_valid,
   output vpi_pkg::vpi_byp_t        byp_a,
   output vpi_pkg::vpi_byp_t        byp_b,
   output logic                     rf_we,
   output logic [5:0]               rf_waddr,
   output logic                     pipe_stalled,
   output logic                     bad_link_write
);
   import vpi_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Stage registers and their next values.
   vpi_stage_t dec_reg, dec_next;
   vpi_stage_t rd_reg,  rd_next;
   vpi_stage_t ex1_reg, ex1_next;
   vpi_stage_t ex2_reg, ex2_next;
   vpi_stage_t wb_reg,  wb_next;
   vpi_fgate_t fg_reg,  fg_next;
   vpi_byp_t   byp_a_reg, byp_a_next;
   vpi_byp_t   byp_b_reg, byp_b_next;
   logic       we_reg,   we_next;
   logic [5:0] wa_reg,   wa_next;
   logic       stl_reg,  stl_next;
   logic       bad_reg,  bad_next;

   ////////////////////////////////////////////////////////////////////////////
   // Hazard signals.
   vpi_stage_t fetched;
   vpi_byp_t   sel_a;
   vpi_byp_t   sel_b;
   logic       stall_a;
   logic       stall_b;
   logic       lnk_busy;
   logic       lnk_load;
   logic       hold_all;
   logic       haz;
   logic       rd_hold;
   logic       dec_hold;
   logic       dec_slr;
   logic       dec_drain;
   logic       link_wait;
   logic       drain_wait;
   logic       dec_is_br;
   logic       br_fire;
   logic       wb_link_ok;

   vpi_src_check u_chk_a (
      .en       (rd_reg.v),
      .src      (rd_reg.src_a),
      .ex1_v    (ex1_reg.v),
      .ex1_dest (ex1_reg.dest),
      .ex1_lat  (ex1_reg.lat),
      .ex2_v    (ex2_reg.v),
      .ex2_dest (ex2_reg.dest),
      .ex2_lat  (ex2_reg.lat),
      .wb_v     (wb_reg.v),
      .wb_dest  (wb_reg.dest),
      .stall    (stall_a),
      .sel      (sel_a)
   );

   vpi_src_check u_chk_b (
      .en       (rd_reg.v),
      .src      (rd_reg.src_b),
      .ex1_v    (ex1_reg.v),
      .ex1_dest (ex1_reg.dest),
      .ex1_lat  (ex1_reg.lat),
      .ex2_v    (ex2_reg.v),
      .ex2_dest (ex2_reg.dest),
      .ex2_lat  (ex2_reg.lat),
      .wb_v     (wb_reg.v),
      .wb_dest  (wb_reg.dest),
      .stall    (stall_b),
      .sel      (sel_b)
   );

   vpi_link_guard u_link (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .load    (lnk_load),
      .busy    (lnk_busy)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Stall, branch and drain decisions.
   always_comb begin
      fetched.v     = 1'b1;
      fetched.dest  = fch_dest;
      fetched.src_a = fch_src_a;
      fetched.src_b = fch_src_b;
      fetched.lat   = fch_lat;
      fetched.wload = fch_word_load;
      fetched.kind  = fch_kind;
      hold_all   = long_busy;
      haz        = stall_a || stall_b;
      rd_hold    = hold_all || haz;
      dec_slr    = dec_reg.v && ((dec_reg.kind == VPI_OP_LINKBR) || (dec_reg.kind == VPI_OP_RFI));
      link_wait  = dec_slr && (lnk_busy || (rd_reg.v && (rd_reg.dest == `VPI_LINK_REG)));
      dec_drain  = dec_reg.v && ((dec_reg.kind == VPI_OP_RFI) || (dec_reg.kind == VPI_OP_PSWMASK) ||
                                 (dec_reg.kind == VPI_OP_SYNCINS));
      drain_wait = dec_drain && (rd_reg.v || ex1_reg.v || ex2_reg.v || wb_reg.v);
      dec_hold   = rd_hold || link_wait || drain_wait;
      dec_is_br  = (dec_reg.kind == VPI_OP_BRANCH) || (dec_reg.kind == VPI_OP_LINKBR);
      br_fire    = dec_reg.v && !dec_hold && ((dec_is_br && br_taken) || (dec_reg.kind == VPI_OP_RFI));
      fch_flush  = br_fire;
      fch_take   = fch_valid && !dec_hold && !br_fire && (fg_reg == VPI_FG_OPEN);
      lnk_load   = rd_reg.v && !rd_hold && (rd_reg.dest == `VPI_LINK_REG);
      wb_link_ok = (wb_reg.lat == `VPI_LAT_ONE) || wb_reg.wload;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state of the pipeline.
   always_comb begin
      fg_next = fg_reg;
      case (fg_reg)
         VPI_FG_OPEN: begin
            if (br_fire && br_line_cross) begin
               fg_next = VPI_FG_LINE;
            end
         end
         VPI_FG_LINE: begin
            fg_next = VPI_FG_OPEN;
         end
         default: begin
            fg_next = VPI_FG_OPEN;
         end
      endcase
      wb_next  = hold_all ? wb_reg : ex2_reg;
      ex2_next = hold_all ? ex2_reg : ex1_reg;
      if (hold_all) begin
         ex1_next = ex1_reg;
      end else if (haz) begin
         ex1_next = '0;
      end else begin
         ex1_next = rd_reg;
      end
      if (rd_hold) begin
         rd_next = rd_reg;
      end else if (dec_reg.v && !dec_hold) begin
         rd_next = dec_reg;
      end else begin
         rd_next = '0;
      end
      if (dec_hold) begin
         dec_next = dec_reg;
      end else if (fch_take) begin
         dec_next = fetched;
      end else begin
         dec_next = '0;
      end
      byp_a_next = hold_all ? byp_a_reg : (haz ? VPI_BYP_RF : sel_a);
      byp_b_next = hold_all ? byp_b_reg : (haz ? VPI_BYP_RF : sel_b);
      we_next    = wb_reg.v && !hold_all && (wb_reg.dest != `VPI_ZERO_REG) &&
                   ((wb_reg.dest != `VPI_LINK_REG) || wb_link_ok);
      wa_next    = wb_reg.dest;
      bad_next   = wb_reg.v && !hold_all && (wb_reg.dest == `VPI_LINK_REG) && !wb_link_ok;
      stl_next   = dec_hold || br_fire || (fg_reg == VPI_FG_LINE);
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         fg_reg    <= VPI_FG_OPEN;
         dec_reg   <= '0;
         rd_reg    <= '0;
         ex1_reg   <= '0;
         ex2_reg   <= '0;
         wb_reg    <= '0;
         byp_a_reg <= VPI_BYP_RF;
         byp_b_reg <= VPI_BYP_RF;
         we_reg    <= 1'b0;
         wa_reg    <= 6'h00;
         stl_reg   <= 1'b0;
         bad_reg   <= 1'b0;
      end else begin
         fg_reg    <= fg_next;
         dec_reg   <= dec_next;
         rd_reg    <= rd_next;
         ex1_reg   <= ex1_next;
         ex2_reg   <= ex2_next;
         wb_reg    <= wb_next;
         byp_a_reg <= byp_a_next;
         byp_b_reg <= byp_b_next;
         we_reg    <= we_next;
         wa_reg    <= wa_next;
         stl_reg   <= stl_next;
         bad_reg   <= bad_next;
      end
   end

   assign rd_valid       = rd_reg.v;
   assign ex1_valid      = ex1_reg.v;
   assign ex2_valid      = ex2_reg.v;
   assign wb_valid       = wb_reg.v;
   assign byp_a          = byp_a_reg;
   assign byp_b          = byp_b_reg;
   assign rf_we          = we_reg;
   assign rf_waddr       = wa_reg;
   assign pipe_stalled   = stl_reg;
   assign bad_link_write = bad_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   a_taken_one_bubble: assert property (br_fire && !br_line_cross |->
                                        !fch_take ##1 (fg_reg == VPI_FG_OPEN && pipe_stalled))
      else $error("Taken branch stall is not one cycle.");
   a_line_extra_stall: assert property (br_fire && br_line_cross |=> !fch_take ##1 fg_reg == VPI_FG_OPEN)
      else $error("Line crossing stall missing.");
   a_long_freeze: assert property (long_busy |=> !rf_we && $stable(wb_reg))
      else $error("Pipeline moved during long operation.");
   a_hazard_bubble: assert property (haz && !hold_all |=> !ex1_valid && $stable(rd_reg))
      else $error("Hazard did not insert a bubble.");
   a_link_gap: assert property (lnk_load |=> (dec_slr && !dec_hold) == 1'b0 [*4])
      else $error("Shadow operation left decode inside link latency.");
   a_link_write_legal: assert property (rf_we && rf_waddr == `VPI_LINK_REG |-> $past(wb_link_ok))
      else $error("Illegal link register write committed.");
   a_drain_empty: assert property (dec_drain && !dec_hold |-> !rd_reg.v && !ex1_reg.v && !ex2_reg.v && !wb_reg.v)
      else $error("Drain operation advanced into a busy pipeline.");
   a_bypass_near: assert property (rd_reg.v && !rd_hold && ex1_reg.v && ex1_reg.dest == rd_reg.src_a &&
                                   rd_reg.src_a != `VPI_ZERO_REG |=> byp_a == VPI_BYP_EX2)
      else $error("Nearest bypass not selected.");
   a_commit_follows: assert property (wb_reg.v && !hold_all && wb_reg.dest != `VPI_ZERO_REG &&
                                      wb_reg.dest != `VPI_LINK_REG |=> rf_we && rf_waddr == $past(wb_reg.dest))
      else $error("Writeback result not committed.");

   ////////////////////////////////////////////////////////////////////////////
   // Stage movement, branch cost and commit checks.
   a_taken_resume: assert property (br_fire && !br_line_cross |=> !fch_valid || dec_hold || fch_take)
      else $error("Fetch not resumed after taken branch stall.");
   a_untaken_free: assert property (dec_reg.v && !dec_hold && dec_reg.kind == VPI_OP_BRANCH && !br_taken |->
                                    !fch_flush && (!fch_valid || fch_take))
      else $error("Untaken branch cost a cycle.");
   a_flush_once: assert property (fch_flush |-> !fch_take ##1 !fch_flush)
      else $error("Fetch flush longer than one cycle.");
   a_freeze_front: assert property (hold_all |=> $stable(dec_reg) && $stable(rd_reg) && $stable(ex1_reg))
      else $error("Early stages moved during freeze.");
   a_stall_shown: assert property (dec_hold |=> pipe_stalled)
      else $error("Decode stall not reported.");
   a_read_to_exec: assert property (rd_reg.v && !rd_hold |=> ex1_valid)
      else $error("Bundle leaving read did not start execution.");
   a_exec_advance: assert property (ex1_reg.v && !hold_all |=> ex2_valid)
      else $error("First execute stage did not advance.");
   a_wb_advance: assert property (ex2_reg.v && !hold_all |=> wb_valid)
      else $error("Second execute stage did not advance.");
   a_bad_link_drop: assert property (bad_link_write |-> !rf_we)
      else $error("Illegal link write reached the register file.");
   a_zero_never: assert property (rf_we |-> rf_waddr != `VPI_ZERO_REG)
      else $error("Write to the zero register committed.");

   c_taken_branch: cover property (br_fire ##1 fch_take);
   c_long_freeze:  cover property (long_busy [*3] ##1 !long_busy);
   c_hazard:       cover property (haz ##1 !haz);
   c_drain:        cover property (drain_wait ##[1:8] (dec_drain && !dec_hold));
   c_link_wait:    cover property (link_wait [*4] ##1 !link_wait);

endmodule : vpi_pipe_ctrl

`default_nettype wire

// ---- bench/vpi_fetch_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module vpi_fetch_model (
   input  wire logic               ref_clk,
   input  wire logic               fch_take,
   input  wire logic               fch_flush,
   output var  logic               fch_valid,
   output var  logic [5:0]         fch_dest,
   output var  logic [5:0]         fch_src_a,
   output var  logic [5:0]         fch_src_b,
   output var  logic [1:0]         fch_lat,
   output var  logic               fch_word_load,
   output var  vpi_pkg::vpi_kind_t fch_kind,
   output var  logic               br_taken,
   output var  logic               br_line_cross,
   output var  logic               long_busy
);
   import vpi_pkg::*;
   typedef struct packed {
      vpi_stage_t s;
      logic       tk;
      logic       lx;
   } vpi_fent_t;
   vpi_fent_t q[$];
   vpi_fent_t tgt[$];
   vpi_fent_t dec_reg;
   vpi_fent_t junk_reg;
   vpi_fent_t cur;

   task push(input vpi_fent_t e);
      q.push_back(e);
   endtask : push

   // The slow unit holds writeback for n cycles.
   task hold_long(input int n);
      #1 long_busy = 1'b1;
      repeat (n) @(posedge ref_clk);
      #1 long_busy = 1'b0;
   endtask : hold_long

   // Idle fetch lines carry a pattern that flips every cycle.
   task drive;
      cur = (q.size() > 0) ? q[0] : junk_reg;
      fch_valid = (q.size() > 0);
      fch_dest = cur.s.dest;
      fch_src_a = cur.s.src_a;
      fch_src_b = cur.s.src_b;
      fch_lat = cur.s.lat;
      fch_word_load = cur.s.wload;
      fch_kind = cur.s.kind;
      br_taken = dec_reg.tk;
      br_line_cross = dec_reg.lx;
   endtask : drive

   initial begin
      dec_reg = '0;
      junk_reg = '0;
      long_busy = 1'b0;
      drive();
   end

   always @(posedge ref_clk) begin
      if (fch_valid && fch_take) begin
         dec_reg = q.pop_front();
      end
      if (fch_flush) begin
         dec_reg.tk = 1'b0;
         q = tgt;
         tgt.delete();
      end
      junk_reg = ~junk_reg;
      #1 drive();
   end
endmodule : vpi_fetch_model

`default_nettype wire

// ---- bench/vliw_pipeline_interlock_bench.sv ----
`timescale 1ns/10ps
`default_nettype none

module vliw_pipeline_interlock_bench;
   import vpi_pkg::*;
   logic ref_clk, resetn, fch_valid, fch_word_load, br_taken, br_line_cross, long_busy;
   logic [5:0] fch_dest, fch_src_a, fch_src_b, rf_waddr;
   logic [1:0] fch_lat;
   vpi_kind_t  fch_kind;
   vpi_byp_t   byp_a, byp_b;
   logic fch_take, fch_flush, rd_valid, ex1_valid, ex2_valid, wb_valid;
   logic rf_we, pipe_stalled, bad_link_write;
   int   failures, tests_run, cyc, bad_n, st_n;
   int   tk_q[$], fl_q[$], cm_q[$], rd_q[$], wb_q[$];
   logic [5:0] ca_q[$];
   logic [3:0] bq[$];

   vpi_pipe_ctrl dut (.ref_clk, .resetn, .fch_valid, .fch_dest, .fch_src_a, .fch_src_b,
      .fch_lat, .fch_word_load, .fch_kind, .br_taken, .br_line_cross, .long_busy,
      .fch_take, .fch_flush, .rd_valid, .ex1_valid, .ex2_valid, .wb_valid, .byp_a,
      .byp_b, .rf_we, .rf_waddr, .pipe_stalled, .bad_link_write);
   vpi_fetch_model m (.ref_clk, .fch_take, .fch_flush, .fch_valid, .fch_dest,
      .fch_src_a, .fch_src_b, .fch_lat, .fch_word_load, .fch_kind, .br_taken,
      .br_line_cross, .long_busy);

   ////////////////////////////////////////////////////////////////////////////
   initial ref_clk = 1'b0;
   always #2 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      cyc++;
      if (fch_valid && fch_take) tk_q.push_back(cyc);
      if (fch_flush) fl_q.push_back(cyc);
      if (rf_we && rf_waddr != 6'h00) begin
         cm_q.push_back(cyc);
         ca_q.push_back(rf_waddr);
      end
      if (bad_link_write) bad_n++;
      if (pipe_stalled) st_n++;
      if (rd_valid) rd_q.push_back(cyc);
      if (wb_valid) wb_q.push_back(cyc);
      if (ex1_valid) bq.push_back({byp_a, byp_b});
   end

   ////////////////////////////////////////////////////////////////////////////
   task finish_test;
      if (failures == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [26:0] mk(input logic [5:0] d, input logic [5:0] a,
      input logic [1:0] l, input logic w, input vpi_kind_t k, input logic t, input logic x);
      return {1'b1, d, a, a, l, w, k, t, x};
   endfunction : mk

   task automatic clr;
      tk_q.delete();
      fl_q.delete();
      cm_q.delete();
      ca_q.delete();
      bq.delete();
      bad_n = 0;
      st_n = 0;
      rd_q.delete();
      wb_q.delete();
      m.tgt.delete();
   endtask : clr

   task automatic drain;
      for (int i = 0; i < 60; i++) begin
         @(posedge ref_clk);
         if (i > 4 && m.q.size() == 0 && m.tgt.size() == 0 && !pipe_stalled &&
             !(rd_valid | ex1_valid | ex2_valid | wb_valid)) break;
      end
      repeat (2) @(posedge ref_clk);
   endtask : drain

   ////////////////////////////////////////////////////////////////////////////
   task automatic lat_case(input logic [1:0] l, input vpi_byp_t e);
      clr();
      m.push(mk(6'h07, 6'h00, l, 1'b0, VPI_OP_PLAIN, 1'b0, 1'b0));
      m.push(mk(6'h08, 6'h07, 2'h1, 1'b0, VPI_OP_PLAIN, 1'b0, 1'b0));
      drain();
      chk(8'(cm_q[0] - tk_q[0]), 8'h06);
      chk(8'(rd_q[0] - tk_q[0]), 8'h02);
      chk(8'(wb_q[0] - tk_q[0]), 8'h05);
      chk(8'(cm_q[1] - cm_q[0]), {6'h00, l});
      chk({4'h0, bq[1]}, {4'h0, e, e});
      chk({2'h0, ca_q[1]}, 8'h08);
   endtask : lat_case

   task automatic br_case(input logic t, input logic x, input logic [7:0] e);
      clr();
      m.push(mk(6'h00, 6'h00, 2'h1, 1'b0, VPI_OP_BRANCH, t, x));
      m.push(mk(6'h09, 6'h00, 2'h1, 1'b0, VPI_OP_PLAIN, 1'b0, 1'b0));
      m.tgt.push_back(mk(6'h0A, 6'h00, 2'h1, 1'b0, VPI_OP_PLAIN, 1'b0, 1'b0));
      drain();
      chk(8'(tk_q[1] - tk_q[0]), e);
      chk(8'(st_n), e - 8'h01);
      chk(8'(fl_q.size()), {7'h00, t});
      chk({2'h0, ca_q[0]}, t ? 8'h0A : 8'h09);
      chk(8'(ca_q.size()), 8'h01);
   endtask : br_case

   task automatic dr_case(input vpi_kind_t k, input logic [7:0] e);
      logic [26:0] n;
      clr();
      n = mk(6'h0C, 6'h00, 2'h1, 1'b0, VPI_OP_PLAIN, 1'b0, 1'b0);
      m.push(mk(6'h0B, 6'h00, 2'h3, 1'b0, VPI_OP_PLAIN, 1'b0, 1'b0));
      m.push(mk(6'h00, 6'h00, 2'h1, 1'b0, k, 1'b0, 1'b0));
      if (k == VPI_OP_RFI) m.tgt.push_back(n);
      else m.push(n);
      drain();
      chk(8'(tk_q[2] - tk_q[0]), e);
   endtask : dr_case

   task automatic long_case;
      clr();
      m.push(mk(6'h0D, 6'h00, 2'h1, 1'b0, VPI_OP_PLAIN, 1'b0, 1'b0));
      for (int i = 0; i < 20; i++) begin
         @(posedge ref_clk);
         if (ex2_valid === 1'b1) break;
      end
      m.hold_long(3);
      drain();
      chk(8'(cm_q[0] - tk_q[0]), 8'h09);
   endtask : long_case

   task automatic lk_case(input logic [5:0] d, input int lo, input int hi);
      int df;
      clr();
      m.push(mk(d, d, 2'h1, 1'b0, VPI_OP_PLAIN, 1'b0, 1'b0));
      m.push(mk(6'h00, 6'h00, 2'h1, 1'b0, VPI_OP_LINKBR, 1'b1, 1'b0));
      drain();
      df = fl_q[0] - tk_q[0];
      chk({7'h00, df >= lo && df <= hi}, 8'h01);
   endtask : lk_case

   task automatic bl_case(input logic [1:0] l, input logic w, input logic b);
      clr();
      m.push(mk(6'h3F, 6'h00, l, w, VPI_OP_PLAIN, 1'b0, 1'b0));
      drain();
      chk(8'(bad_n), {7'h00, b});
      chk(8'(ca_q.size()), {7'h00, ~b});
   endtask : bl_case

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3000) @(posedge ref_clk);
      failures++;
      finish_test();
   end

   initial begin
      resetn = 1'b0;
      repeat (16) @(posedge ref_clk);
      #1 resetn = 1'b1;
      chk({rd_valid, ex1_valid, ex2_valid, wb_valid, rf_we, pipe_stalled, bad_link_write, fch_flush}, 8'h00);
      chk({4'h0, byp_a, byp_b}, 8'h00);
      @(posedge ref_clk);
      lat_case(2'h1, VPI_BYP_EX2);
      lat_case(2'h2, VPI_BYP_WB);
      lat_case(2'h3, VPI_BYP_RET);
      br_case(1'b0, 1'b0, 8'h01);
      br_case(1'b1, 1'b0, 8'h02);
      br_case(1'b1, 1'b1, 8'h03);
      dr_case(VPI_OP_RFI, 8'h07);
      dr_case(VPI_OP_PSWMASK, 8'h06);
      dr_case(VPI_OP_SYNCINS, 8'h06);
      long_case();
      lk_case(6'h05, 2, 2);
      lk_case(6'h3F, 6, 7);
      bl_case(2'h1, 1'b0, 1'b0);
      bl_case(2'h2, 1'b0, 1'b1);
      bl_case(2'h3, 1'b0, 1'b1);
      bl_case(2'h3, 1'b1, 1'b0);
      finish_test();
   end
endmodule : vliw_pipeline_interlock_bench

`default_nettype wire
